/* File: energy_accum_mode_consts.svh */
/*
 * Offsets, field positions, reset values and widths shared by the
 * energy accumulation mode configuration logic.
 * Assumes inclusion by bare name from files that need these values.
 */
`ifndef ENERGY_ACCUM_MODE_CONSTS_SVH
`define ENERGY_ACCUM_MODE_CONSTS_SVH

`define REG_ADDR_W 7
`define COMP_MODE_ADDR 7'h16
`define LINE_CYCLE_MODE_ADDR 7'h17
`define LINE_RATE_ADDR 7'h10

`define COMP_PHASE_SUM_LSB 2
`define COMP_MAGNITUDE_BIT 5
`define COMP_SIGN_ADJ_BIT 6
`define COMP_IDLE_THR_BIT 7
`define COMP_MODE_RESET 8'h1C

`define LC_ACTIVE_BIT 0
`define LC_REACTIVE_BIT 1
`define LC_APPARENT_BIT 2
`define LC_ZX_SEL_LSB 3
`define LC_CLEAR_ON_READ_BIT 6
`define LC_PERIOD_SEL_BIT 7
`define LINE_CYCLE_MODE_RESET 8'h78

`define LINE_CYCLE_COUNT_W 16

`endif

/* File: energy_accum_mode_pkg.sv */
/*
 * Types for the energy accumulation mode configuration logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package energy_accum_mode_pkg;
    typedef enum logic [0:0] {
        LC_IDLE = 1'b0,
        LC_RUN = 1'b1
    } lc_state_t;
endpackage

/* File: line_cycle_counter.sv */
/*
 * Zero-crossing counter that times line-cycle accumulation.
 * Assumes one-cycle zero-crossing pulses synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "energy_accum_mode_consts.svh"

module line_cycle_counter
    import energy_accum_mode_pkg::*;
#(
    parameter int COUNT_W = `LINE_CYCLE_COUNT_W
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    input wire logic [2:0] zero_cross_i,
    input wire logic [2:0] zero_cross_phase_select_i,
    input wire logic [COUNT_W-1:0] cycle_target_i,
    output logic done_o
);
    initial begin
        if (COUNT_W < 2 || COUNT_W > 31) begin
            $error("line_cycle_counter: COUNT_W out of range");
        end
    end

    lc_state_t state_reg;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W:0] count_next;
    logic [2:0] hits;
    logic [1:0] hit_count;

    // Every selected phase adds its own crossings
    assign hits = zero_cross_i & zero_cross_phase_select_i;
    assign hit_count = 2'(hits[0]) + 2'(hits[1]) + 2'(hits[2]);
    assign count_next = {1'b0, count_reg} + {{(COUNT_W-1){1'b0}}, hit_count};

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= LC_IDLE;
            count_reg <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state_reg)
                LC_IDLE: begin
                    count_reg <= '0;
                    if (enable_i) begin
                        state_reg <= LC_RUN;
                    end
                end
                LC_RUN: begin
                    if (!enable_i) begin
                        state_reg <= LC_IDLE;
                    end else if (count_next >= {1'b0, cycle_target_i}) begin
                        // Zero target never completes rather than firing
                        // on every clock
                        if (cycle_target_i != '0) begin
                            done_o <= 1'b1;
                            count_reg <= '0;
                        end
                    end else begin
                        count_reg <= count_next[COUNT_W-1:0];
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: energy_accum_mode_config.sv */
/*
 * Computation mode and line-cycle accumulation mode registers, with the
 * pulse-rate combining, clear-on-read and line-rate selection they steer.
 * Assumes a host register port synchronous to clk_i and per-phase energy
 * increments, zero-crossing pulses and accumulator read strobes from the
 * surrounding metering datapath.
 */
// How it works
// - Phase-sum select, bits 2-4, reset all ones
// - Magnitude bit sums absolute active contributions
// - Sign-adjusted bit drives signed reactive sum
// - Reactive sign flips where active is negative
// - Sign adjustment touches pulse only, not accumulators
// - Bit 0 puts active accumulators line-cycle
// - Bit 1 puts reactive accumulators line-cycle
// - Bit 2 puts apparent accumulators line-cycle
// - Zero-cross phase select, bits 3-5, ones
// - Selected phases' crossings all counted together
// - Clear-on-read zeroes accumulator after its read
// - Period select makes line rate show period
// - Line-cycle done event, masked interrupt request
`timescale 1ns/1ps
`default_nettype none
`include "energy_accum_mode_consts.svh"

module energy_accum_mode_config
    import energy_accum_mode_pkg::*;
#(
    parameter int ENERGY_W = 24,
    parameter int RATE_W = 16,
    parameter int COUNT_W = `LINE_CYCLE_COUNT_W
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [`REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic signed [ENERGY_W-1:0] active_incr_a_i,
    input wire logic signed [ENERGY_W-1:0] active_incr_b_i,
    input wire logic signed [ENERGY_W-1:0] active_incr_c_i,
    input wire logic signed [ENERGY_W-1:0] reactive_incr_a_i,
    input wire logic signed [ENERGY_W-1:0] reactive_incr_b_i,
    input wire logic signed [ENERGY_W-1:0] reactive_incr_c_i,
    input wire logic [8:0] accum_read_i,
    input wire logic [2:0] zero_cross_i,
    input wire logic [COUNT_W-1:0] cycle_target_i,
    input wire logic line_cycle_irq_mask_i,
    input wire logic [RATE_W-1:0] line_line_rate_reg_i,
    input wire logic [RATE_W-1:0] line_period_i,
    output logic signed [ENERGY_W+1:0] active_pulse_out_rate_o,
    output logic signed [ENERGY_W+1:0] reactive_pulse_out_rate_o,
    output logic [8:0] accum_clear_o,
    output logic active_line_cycle_en_o,
    output logic reactive_line_cycle_en_o,
    output logic apparent_line_cycle_en_o,
    output logic idle_threshold_en_o,
    output logic [RATE_W-1:0] line_rate_reg_o,
    output logic line_cycle_done_flag_o,
    output logic line_cycle_irq_o
);
    initial begin
        if (ENERGY_W < 2 || ENERGY_W > 60 || RATE_W < 1 || RATE_W > 32) begin
            $error("energy_accum_mode_config: width out of range");
        end
    end

    localparam int SUM_W = ENERGY_W + 2;

    logic [7:0] computation_mode_reg;
    logic [7:0] line_cycle_mode_reg;
    logic lc_done;

    wire [2:0] phase_sum_select =
        computation_mode_reg[`COMP_PHASE_SUM_LSB +: 3];
    wire magnitude_only_mode = computation_mode_reg[`COMP_MAGNITUDE_BIT];
    wire sign_adjusted_reactive = computation_mode_reg[`COMP_SIGN_ADJ_BIT];
    wire [2:0] zero_cross_phase_select =
        line_cycle_mode_reg[`LC_ZX_SEL_LSB +: 3];
    wire clear_on_read_en = line_cycle_mode_reg[`LC_CLEAR_ON_READ_BIT];
    wire line_rate_period_select = line_cycle_mode_reg[`LC_PERIOD_SEL_BIT];
    wire any_line_cycle = |line_cycle_mode_reg[2:0];

    // One phase's share of a pulse rate, widened to the sum width
    function automatic logic signed [SUM_W-1:0] phase_term(
        input logic signed [ENERGY_W-1:0] value,
        input logic selected,
        input logic magnitude,
        input logic flip
    );
        logic signed [SUM_W-1:0] wide;
        wide = SUM_W'(value);
        if (!selected) begin
            phase_term = '0;
        end else if (magnitude && wide < 0) begin
            phase_term = -wide;
        end else if (flip) begin
            phase_term = -wide;
        end else begin
            phase_term = wide;
        end
    endfunction

    // Host register writes; defaults on reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            computation_mode_reg <= `COMP_MODE_RESET;
            line_cycle_mode_reg <= `LINE_CYCLE_MODE_RESET;
        end else if (reg_write_i) begin
            if (reg_addr_i == `COMP_MODE_ADDR) begin
                computation_mode_reg <= reg_wdata_i;
            end
            if (reg_addr_i == `LINE_CYCLE_MODE_ADDR) begin
                line_cycle_mode_reg <= reg_wdata_i;
            end
        end
    end

    // Host register reads; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_read_i;
            if (reg_read_i) begin
                if (reg_addr_i == `COMP_MODE_ADDR) begin
                    reg_rdata_o <= computation_mode_reg;
                end else if (reg_addr_i == `LINE_CYCLE_MODE_ADDR) begin
                    reg_rdata_o <= line_cycle_mode_reg;
                end else begin
                    reg_rdata_o <= 8'h00;
                end
            end
        end
    end

    // Pulse rates only; accumulator contents never pass through here
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            active_pulse_out_rate_o <= '0;
            reactive_pulse_out_rate_o <= '0;
        end else begin
            active_pulse_out_rate_o <=
                phase_term(active_incr_a_i, phase_sum_select[0],
                           magnitude_only_mode, 1'b0) +
                phase_term(active_incr_b_i, phase_sum_select[1],
                           magnitude_only_mode, 1'b0) +
                phase_term(active_incr_c_i, phase_sum_select[2],
                           magnitude_only_mode, 1'b0);
            reactive_pulse_out_rate_o <=
                phase_term(reactive_incr_a_i, phase_sum_select[0], 1'b0,
                           sign_adjusted_reactive && active_incr_a_i < 0) +
                phase_term(reactive_incr_b_i, phase_sum_select[1], 1'b0,
                           sign_adjusted_reactive && active_incr_b_i < 0) +
                phase_term(reactive_incr_c_i, phase_sum_select[2], 1'b0,
                           sign_adjusted_reactive && active_incr_c_i < 0);
        end
    end

    // Mode levels to the accumulators and the no-load detector
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            active_line_cycle_en_o <= 1'b0;
            reactive_line_cycle_en_o <= 1'b0;
            apparent_line_cycle_en_o <= 1'b0;
            idle_threshold_en_o <= 1'b0;
        end else begin
            active_line_cycle_en_o <=
                line_cycle_mode_reg[`LC_ACTIVE_BIT];
            reactive_line_cycle_en_o <=
                line_cycle_mode_reg[`LC_REACTIVE_BIT];
            apparent_line_cycle_en_o <=
                line_cycle_mode_reg[`LC_APPARENT_BIT];
            idle_threshold_en_o <=
                computation_mode_reg[`COMP_IDLE_THR_BIT];
        end
    end

    // Clear follows the read, so the read data is taken first.
    // Left enabled in line-cycle mode, reads still clear: host's care.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            accum_clear_o <= 9'h000;
        end else begin
            accum_clear_o <= clear_on_read_en ? accum_read_i : 9'h000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            line_rate_reg_o <= '0;
        end else begin
            line_rate_reg_o <= line_rate_period_select ?
                line_period_i : line_line_rate_reg_i;
        end
    end

    line_cycle_counter #(
        .COUNT_W(COUNT_W)
    ) u_line_cycle_counter (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .enable_i(any_line_cycle),
        .zero_cross_i(zero_cross_i),
        .zero_cross_phase_select_i(zero_cross_phase_select),
        .cycle_target_i(cycle_target_i),
        .done_o(lc_done)
    );

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            line_cycle_done_flag_o <= 1'b0;
            line_cycle_irq_o <= 1'b0;
        end else begin
            line_cycle_done_flag_o <= lc_done;
            line_cycle_irq_o <= lc_done && line_cycle_irq_mask_i;
        end
    end
endmodule
`default_nettype wire

/* File: energy_accum_mode_config_asserts.sv */
/*
 * Port-level checker for the energy accumulation mode configuration block.
 * Assumes binding to the block's top module; mirrors both mode registers
 * from the write strobes seen at the ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "energy_accum_mode_consts.svh"

module energy_accum_mode_config_asserts
    import energy_accum_mode_pkg::*;
#(
    parameter int RATE_W = 16
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [`REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic [8:0] accum_read_i,
    input wire logic [RATE_W-1:0] line_line_rate_reg_i,
    input wire logic [RATE_W-1:0] line_period_i,
    input wire logic [8:0] accum_clear_o,
    input wire logic active_line_cycle_en_o,
    input wire logic reactive_line_cycle_en_o,
    input wire logic apparent_line_cycle_en_o,
    input wire logic idle_threshold_en_o,
    input wire logic [RATE_W-1:0] line_rate_reg_o,
    input wire logic line_cycle_done_flag_o,
    input wire logic line_cycle_irq_o
);
    logic [7:0] comp_m;
    logic [7:0] lc_m;

    // Unmapped writes must leave both copies alone
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            comp_m <= `COMP_MODE_RESET;
            lc_m <= `LINE_CYCLE_MODE_RESET;
        end else if (reg_write_i && reg_addr_i == `COMP_MODE_ADDR) begin
            comp_m <= reg_wdata_i;
        end else if (reg_write_i && reg_addr_i == `LINE_CYCLE_MODE_ADDR) begin
            lc_m <= reg_wdata_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_rvalid_pulse: assert property (
        !$past(reset_i) |-> reg_rvalid_o == $past(reg_read_i)
    ) else $error("read valid out of step with read strobe");
    a_rdata_match: assert property (
        reg_rvalid_o && !$past(reset_i) |-> reg_rdata_o ==
        $past(reg_addr_i == `COMP_MODE_ADDR ? comp_m :
        reg_addr_i == `LINE_CYCLE_MODE_ADDR ? lc_m : 8'h00)
    ) else $error("read data differs from register contents");
    a_clear_on_read: assert property (
        !$past(reset_i) |-> accum_clear_o ==
        ($past(lc_m[6]) ? $past(accum_read_i) : 9'h000)
    ) else $error("accumulator clear not tied to read");
    a_line_enables: assert property (
        !$past(reset_i) |-> {apparent_line_cycle_en_o,
        reactive_line_cycle_en_o, active_line_cycle_en_o} == $past(lc_m[2:0])
    ) else $error("line-cycle enables differ from mode bits");
    a_idle_enable: assert property (
        !$past(reset_i) |-> idle_threshold_en_o == $past(comp_m[7])
    ) else $error("no-load enable differs from mode bit");
    a_line_rate: assert property (
        !$past(reset_i) |-> line_rate_reg_o == ($past(lc_m[7]) ?
        $past(line_period_i) : $past(line_line_rate_reg_i))
    ) else $error("line rate shows the wrong measure");
    a_irq_needs_done: assert property (
        line_cycle_irq_o |-> line_cycle_done_flag_o
    ) else $error("interrupt without line-cycle done");
    a_done_needs_mode: assert property (
        line_cycle_done_flag_o |-> $past(lc_m[2:0] != 3'h0, 2)
    ) else $error("line-cycle done with no accumulator in that mode");
endmodule

bind energy_accum_mode_config energy_accum_mode_config_asserts #(
    .RATE_W(RATE_W)
) chk_inst (.*);

`default_nettype wire

/* File: host_model.sv */
/*
 * Host controller model driving the register strobe port.
 * Assumes a one-cycle strobe protocol with registered read data.
 */
`timescale 1ns/1ps
`default_nettype none
`include "energy_accum_mode_consts.svh"

module host_model (
    input wire logic clk_i,
    input wire logic reg_rvalid_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [`REG_ADDR_W-1:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_write_o,
    output logic reg_read_o
);
    initial begin
        reg_addr_o = 7'h00;
        reg_wdata_o = 8'h00;
        reg_write_o = 1'b0;
        reg_read_o = 1'b0;
    end

    // Line-cycle mode and read-with-clear do not mix, so drop the clear
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        if (a == `LINE_CYCLE_MODE_ADDR && d[2:0] != 3'h0) begin
            reg_wdata_o = d & 8'hBF;
        end
        reg_write_o = 1'b1;
        @(posedge clk_i);
        #1;
        reg_write_o = 1'b0;
        reg_addr_o = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        reg_addr_o = a;
        reg_read_o = 1'b1;
        @(posedge clk_i);
        #1;
        reg_read_o = 1'b0;
        reg_addr_o = ~a;
        d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
    endtask
endmodule

`default_nettype wire

/* File: energy_accum_mode_config_tb.sv */
/*
 * Self-checking bench for the energy accumulation mode configuration.
 * Assumes the host model on the register port and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`include "energy_accum_mode_consts.svh"

module energy_accum_mode_config_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [6:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, d;
    logic reg_write_i, reg_read_i, reg_rvalid_o;
    logic signed [23:0] active_incr_a_i = 24'sh000005;
    logic signed [23:0] active_incr_b_i = 24'shFFFFFD;
    logic signed [23:0] active_incr_c_i = 24'sh000007;
    logic signed [23:0] reactive_incr_a_i = 24'sh000002;
    logic signed [23:0] reactive_incr_b_i = 24'sh00000B;
    logic signed [23:0] reactive_incr_c_i = 24'shFFFFFC;
    logic [8:0] accum_read_i = 9'h000;
    logic [8:0] accum_clear_o;
    logic [2:0] zero_cross_i = 3'h0;
    logic [15:0] cycle_target_i = 16'h0004;
    logic line_cycle_irq_mask_i = 1'b1;
    logic [15:0] line_line_rate_reg_i = 16'h0032;
    logic [15:0] line_period_i = 16'h1388;
    logic [15:0] line_rate_reg_o;
    logic signed [25:0] active_pulse_out_rate_o, reactive_pulse_out_rate_o;
    logic active_line_cycle_en_o, reactive_line_cycle_en_o;
    logic apparent_line_cycle_en_o, idle_threshold_en_o;
    logic line_cycle_done_flag_o, line_cycle_irq_o;
    logic [7:0] modes [7] = '{8'h1C, 8'h3C, 8'h5C, 8'h04, 8'h08, 8'h70, 8'hF0};
    int mismatches = 0;
    int n_compared = 0;
    int n_done = 0;
    int n_irq = 0;
    int cyc = 0;

    energy_accum_mode_config energy_accum_mode_config_inst (.*);
    host_model host_model_inst (
        .clk_i(clk_i),
        .reg_rvalid_i(reg_rvalid_o),
        .reg_rdata_i(reg_rdata_o),
        .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i),
        .reg_write_o(reg_write_i),
        .reg_read_o(reg_read_i)
    );

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        n_done <= n_done + line_cycle_done_flag_o;
        n_irq <= n_irq + line_cycle_irq_o;
        if (cyc == 3000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [25:0] got, input logic [25:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Magnitude and sign adjustment both key on a negative active term
    function automatic logic [25:0] rate(input logic [7:0] m, input logic r);
        logic signed [23:0] a [3];
        logic signed [23:0] q [3];
        logic signed [25:0] s;
        logic signed [25:0] v;
        a = '{active_incr_a_i, active_incr_b_i, active_incr_c_i};
        q = '{reactive_incr_a_i, reactive_incr_b_i, reactive_incr_c_i};
        s = 26'sh0000000;
        for (int i = 0; i < 3; i++) begin
            v = r ? q[i] : a[i];
            if ((r ? m[6] : m[5]) && a[i] < 0) begin
                v = -v;
            end
            if (m[2 + i]) begin
                s = s + v;
            end
        end
        return s;
    endfunction

    task automatic pulse(input logic [2:0] z, input logic [8:0] rs);
        @(posedge clk_i);
        #1;
        zero_cross_i = z;
        accum_read_i = rs;
        @(posedge clk_i);
        #1;
        zero_cross_i = 3'h0;
        accum_read_i = 9'h000;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        host_model_inst.rd(`COMP_MODE_ADDR, d);
        chk(d, `COMP_MODE_RESET);
        host_model_inst.rd(`LINE_CYCLE_MODE_ADDR, d);
        chk(d, `LINE_CYCLE_MODE_RESET);
        host_model_inst.wr(7'h05, 8'h33);
        host_model_inst.rd(7'h05, d);
        chk(d, 8'h00);
        chk({idle_threshold_en_o, line_rate_reg_o}, {1'b0, line_line_rate_reg_i});
        $display("test reset done");
        host_model_inst.wr(`LINE_CYCLE_MODE_ADDR, 8'hC0);
        foreach (modes[i]) begin
            host_model_inst.wr(`COMP_MODE_ADDR, modes[i]);
            repeat (2) @(posedge clk_i);
            #1;
            chk(active_pulse_out_rate_o, rate(modes[i], 1'b0));
            chk(reactive_pulse_out_rate_o, rate(modes[i], 1'b1));
            chk(idle_threshold_en_o, modes[i][7]);
            host_model_inst.rd(`COMP_MODE_ADDR, d);
            chk(d, modes[i]);
        end
        chk(line_rate_reg_o, line_period_i);
        $display("test rates done");
        pulse(3'h0, 9'h155);
        chk(accum_clear_o, 9'h155);
        host_model_inst.wr(`LINE_CYCLE_MODE_ADDR, 8'h80);
        pulse(3'h0, 9'h0AA);
        chk(accum_clear_o, 9'h000);
        $display("test clear done");
        host_model_inst.wr(`LINE_CYCLE_MODE_ADDR, 8'h69);
        host_model_inst.rd(`LINE_CYCLE_MODE_ADDR, d);
        chk(d, 8'h29);
        chk(active_line_cycle_en_o, 1'b1);
        pulse(3'b111, 9'h000);
        pulse(3'b010, 9'h000);
        pulse(3'b000, 9'h000);
        chk(26'(n_done), 26'h0);
        pulse(3'b101, 9'h000);
        pulse(3'b000, 9'h000);
        chk(26'(n_done), 26'h1);
        chk(26'(n_irq), 26'h1);
        line_cycle_irq_mask_i = 1'b0;
        repeat (4) pulse(3'b001, 9'h000);
        pulse(3'b000, 9'h000);
        chk(26'(n_done), 26'h2);
        chk(26'(n_irq), 26'h1);
        for (int i = 1; i < 3; i++) begin
            host_model_inst.wr(`LINE_CYCLE_MODE_ADDR, 8'h38 | (8'h01 << i));
            repeat (2) @(posedge clk_i);
            #1;
            chk({apparent_line_cycle_en_o, reactive_line_cycle_en_o,
                active_line_cycle_en_o}, 3'h1 << i);
        end
        $display("test line cycle done");
        end_of_test();
    end
endmodule

`default_nettype wire
